/* File: hw/uoe_pkg.sv */
// Constants for the OTG identification and event-flag block
`default_nettype none
package uoe_pkg;
  localparam logic [7:0] OFF_ID_COMPLEMENT = 8'h04;
  localparam logic [7:0] OFF_BLOCK_REVISION = 8'h08;
  localparam logic [7:0] OFF_EXTRA_INFO = 8'h0C;
  localparam logic [7:0] OFF_EVENT_FLAGS = 8'h10;
  localparam logic [7:0] OFF_EVENT_ENABLES = 8'h14;
  // Implemented flag positions; bits 4 and 1 stay reserved
  localparam logic [7:0] EVENT_MASK = 8'hED;
  localparam int BIT_ID_CHANGE = 7;
  localparam int BIT_MS_TICK = 6;
  localparam int BIT_LINE_CHANGE = 5;
  localparam int BIT_BSESS_VALID = 3;
  localparam int BIT_BSESS_END = 2;
  localparam int BIT_AVBUS_VALID = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // Arbitrary identification values
  localparam logic [7:0] CONFIG_NUMBER_DFLT = 8'h5A;
  localparam logic [7:0] REVISION_DFLT = 8'h01;
  localparam logic [7:0] EXTRA_INFO_DFLT = 8'h3C;
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES_DFLT = MS_PERIOD_NS / CLK_PERIOD_NS;
  // Cycles after reset release before inputs are trusted
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
endpackage : uoe_pkg
`default_nettype wire

/* File: hw/uoe_sync.sv */
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/10ps
`default_nettype none
module uoe_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      sync_out <= '0;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : uoe_sync
`default_nettype wire

/* File: hw/uoe_event_flags.sv */
// OTG identification and event-flag registers behind classic Wishbone
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module uoe_event_flags #(
  parameter logic [7:0] CONFIG_NUMBER = uoe_pkg::CONFIG_NUMBER_DFLT,
  parameter logic [7:0] REVISION = uoe_pkg::REVISION_DFLT,
  parameter logic [7:0] EXTRA_INFO = uoe_pkg::EXTRA_INFO_DFLT,
  parameter int MS_CYCLES = uoe_pkg::MS_CYCLES_DFLT
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CONNECTOR_ID,
  input wire logic LINE_SE0,
  input wire logic LINE_J,
  input wire logic B_SESSION_VALID,
  input wire logic B_SESSION_END,
  input wire logic A_VBUS_VALID,
  output logic OTG_IRQ
);
  localparam int CW = $clog2(MS_CYCLES + 1);
  localparam logic [CW-1:0] MS_LAST = CW'(MS_CYCLES - 1);

  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] off);
    reg_hit = (adr[7:2] == off[7:2]);
  endfunction : reg_hit

  logic rst_meta;
  logic rst_n;

  // Async assert, synchronous release
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  logic [5:0] pins_s;
  uoe_sync #(.WIDTH(6)) u_sync (
    .clk(CLK_SYS),
    .rst_n(rst_n),
    .async_in({CONNECTOR_ID, LINE_SE0, LINE_J, B_SESSION_VALID, B_SESSION_END, A_VBUS_VALID}),
    .sync_out(pins_s)
  );

  wire id_s = pins_s[5];
  wire [1:0] line_code = pins_s[4:3];
  wire bsv_s = pins_s[2];
  wire bse_s = pins_s[1];
  wire avv_s = pins_s[0];

  logic [1:0] settle;
  logic id_d;
  logic bsv_d;
  logic bse_d;
  logic avv_d;
  wire settled = (settle == uoe_pkg::SETTLE_CYCLES);

  // Synchroniser outputs are meaningless until reset values flush out
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      settle <= 2'h0;
      id_d <= 1'b0;
      bsv_d <= 1'b0;
      bse_d <= 1'b0;
      avv_d <= 1'b0;
    end else begin
      if (!settled) settle <= settle + 2'h1;
      id_d <= id_s;
      bsv_d <= bsv_s;
      bse_d <= bse_s;
      avv_d <= avv_s;
    end
  end

  logic [CW-1:0] ms_cnt;
  wire ms_tick = (ms_cnt == MS_LAST);

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt <= '0;
    end else begin
      ms_cnt <= ms_tick ? '0 : ms_cnt + CW'(1);
    end
  end

  // Line state: SE0 is {1,x}, J is {0,1}, K is {0,0}
  logic [1:0] line_prev;
  logic [1:0] line_stable;
  logic line_known;
  logic [CW-1:0] line_cnt;
  wire [1:0] line_norm = line_code[1] ? 2'h2 : line_code;
  wire line_moved = (line_norm != line_prev);
  wire line_done = (line_cnt == MS_LAST) && !line_moved;
  wire line_ev = line_done && line_known && (line_norm != line_stable);

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      line_prev <= 2'h0;
      line_stable <= 2'h0;
      line_known <= 1'b0;
      line_cnt <= '0;
    end else begin
      line_prev <= line_norm;
      if (line_moved || !settled) begin
        line_cnt <= '0;
      end else if (!line_done) begin
        line_cnt <= line_cnt + CW'(1);
      end
      // Count saturates so a long stable state reports once
      if (line_done && settled) begin
        line_stable <= line_norm;
        line_known <= 1'b1;
      end
    end
  end

  logic [7:0] events;
  always_comb begin
    events = 8'h00;
    events[uoe_pkg::BIT_ID_CHANGE] = settled && (id_s != id_d);
    events[uoe_pkg::BIT_MS_TICK] = ms_tick;
    events[uoe_pkg::BIT_LINE_CHANGE] = line_ev;
    events[uoe_pkg::BIT_BSESS_VALID] = settled && (bsv_s != bsv_d);
    // ID high means B role, low means A role
    events[uoe_pkg::BIT_BSESS_END] = settled && id_d && (bse_s != bse_d);
    events[uoe_pkg::BIT_AVBUS_VALID] = settled && !id_d && (avv_s != avv_d);
  end

  wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  wire wr_low = req && WB_WE_I && WB_SEL_I[0];
  wire hit_flags = reg_hit(WB_ADR_I, uoe_pkg::OFF_EVENT_FLAGS);
  wire hit_enables = reg_hit(WB_ADR_I, uoe_pkg::OFF_EVENT_ENABLES);
  wire [7:0] clear_mask = (wr_low && hit_flags) ? WB_DAT_I[7:0] : 8'h00;

  logic [7:0] flags;
  logic [7:0] enables;
  // Set beats clear when both land together
  wire [7:0] next_flags = ((flags & ~clear_mask) | events) & uoe_pkg::EVENT_MASK;
  wire [7:0] next_enables = (wr_low && hit_enables) ?
                            (WB_DAT_I[7:0] & uoe_pkg::EVENT_MASK) : enables;

  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      flags <= uoe_pkg::FLAGS_RESET;
      enables <= uoe_pkg::ENABLES_RESET;
      OTG_IRQ <= 1'b0;
    end else begin
      flags <= next_flags;
      enables <= next_enables;
      OTG_IRQ <= |(flags & enables);
    end
  end

  logic [31:0] rd_data;
  always_comb begin
    rd_data = uoe_pkg::READ_ZERO;
    if (reg_hit(WB_ADR_I, uoe_pkg::OFF_ID_COMPLEMENT)) begin
      rd_data[7:0] = ~CONFIG_NUMBER;
    end else if (reg_hit(WB_ADR_I, uoe_pkg::OFF_BLOCK_REVISION)) begin
      rd_data[7:0] = REVISION;
    end else if (reg_hit(WB_ADR_I, uoe_pkg::OFF_EXTRA_INFO)) begin
      rd_data[7:0] = EXTRA_INFO;
    end else if (hit_flags) begin
      rd_data[7:0] = flags;
    end else if (hit_enables) begin
      rd_data[7:0] = enables;
    end
  end

  // Unmapped addresses still ack, reading zero, so the bus never hangs
  always_ff @(posedge CLK_SYS or negedge rst_n) begin
    if (!rst_n) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= uoe_pkg::READ_ZERO;
    end else begin
      WB_ACK_O <= req;
      if (req && !WB_WE_I) WB_DAT_O <= rd_data;
    end
  end

  property p_id_comp;
    @(posedge CLK_SYS) disable iff (!rst_n)
      req && !WB_WE_I && reg_hit(WB_ADR_I, uoe_pkg::OFF_ID_COMPLEMENT)
      |=> WB_ACK_O && (WB_DAT_O == {24'h000000, ~CONFIG_NUMBER});
  endproperty
  a_id_comp: assert property (p_id_comp) else $error("id complement read wrong");

  property p_revision;
    @(posedge CLK_SYS) disable iff (!rst_n)
      req && !WB_WE_I && reg_hit(WB_ADR_I, uoe_pkg::OFF_BLOCK_REVISION)
      |=> WB_ACK_O && (WB_DAT_O == {24'h000000, REVISION});
  endproperty
  a_revision: assert property (p_revision) else $error("revision read wrong");

  property p_id_change;
    @(posedge CLK_SYS) disable iff (!rst_n)
      settled && (id_s != id_d) |=> flags[uoe_pkg::BIT_ID_CHANGE];
  endproperty
  a_id_change: assert property (p_id_change) else $error("id change not flagged");

  property p_ms_tick;
    @(posedge CLK_SYS) disable iff (!rst_n)
      $rose(flags[uoe_pkg::BIT_MS_TICK]) |-> $past(ms_cnt) == MS_LAST;
  endproperty
  a_ms_tick: assert property (p_ms_tick) else $error("ms flag without timer expiry");

  property p_line_stable;
    @(posedge CLK_SYS) disable iff (!rst_n)
      line_ev |-> (line_cnt == MS_LAST) && (line_norm != line_stable) ##1
      flags[uoe_pkg::BIT_LINE_CHANGE] && (line_stable == $past(line_norm));
  endproperty
  a_line_stable: assert property (p_line_stable) else $error("line change flag wrong");

  property p_line_any;
    @(posedge CLK_SYS) disable iff (!rst_n)
      $past(line_known) && $changed(line_stable) |-> flags[uoe_pkg::BIT_LINE_CHANGE];
  endproperty
  a_line_any: assert property (p_line_any) else $error("line transition missed");

  property p_bsess_valid;
    @(posedge CLK_SYS) disable iff (!rst_n)
      settled && $changed(bsv_s) && $stable(bsv_d) |=> flags[uoe_pkg::BIT_BSESS_VALID];
  endproperty
  a_bsess_valid: assert property (p_bsess_valid) else $error("b valid change missed");

  property p_bsess_end_role;
    @(posedge CLK_SYS) disable iff (!rst_n)
      $rose(flags[uoe_pkg::BIT_BSESS_END]) |-> $past(id_d) && ($past(bse_s) != $past(bse_d));
  endproperty
  a_bsess_end_role: assert property (p_bsess_end_role) else $error("b end flag wrong role");

  property p_avbus_role;
    @(posedge CLK_SYS) disable iff (!rst_n)
      $rose(flags[uoe_pkg::BIT_AVBUS_VALID]) |-> !$past(id_d) && ($past(avv_s) != $past(avv_d));
  endproperty
  a_avbus_role: assert property (p_avbus_role) else $error("a vbus flag wrong role");

  property p_enable_write;
    @(posedge CLK_SYS) disable iff (!rst_n)
      wr_low && hit_enables |=> enables == ($past(WB_DAT_I[7:0]) & uoe_pkg::EVENT_MASK);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable write lost");

  property p_reserved;
    @(posedge CLK_SYS) disable iff (!rst_n)
      ((flags | enables) & ~uoe_pkg::EVENT_MASK) == 8'h00 && WB_DAT_O[31:8] == 24'h000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bit set");

  property p_irq;
    @(posedge CLK_SYS) disable iff (!rst_n)
      ((flags & enables) != 8'h00) |=> OTG_IRQ ##1 1'b1 [*1];
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  property p_irq_quiet;
    @(posedge CLK_SYS) disable iff (!rst_n)
      ((flags & enables) == 8'h00) |=> !OTG_IRQ;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("spurious interrupt");

  property p_w1c;
    @(posedge CLK_SYS) disable iff (!rst_n)
      wr_low && hit_flags && WB_DAT_I[uoe_pkg::BIT_ID_CHANGE] && !events[uoe_pkg::BIT_ID_CHANGE]
      |=> !flags[uoe_pkg::BIT_ID_CHANGE];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_w1c_tick;
    @(posedge CLK_SYS) disable iff (!rst_n)
      wr_low && hit_flags && WB_DAT_I[uoe_pkg::BIT_MS_TICK] && !ms_tick
      |=> !flags[uoe_pkg::BIT_MS_TICK];
  endproperty
  a_w1c_tick: assert property (p_w1c_tick) else $error("tick flag not cleared");

  property p_w1c_line;
    @(posedge CLK_SYS) disable iff (!rst_n)
      wr_low && hit_flags && WB_DAT_I[uoe_pkg::BIT_LINE_CHANGE] && !line_ev
      |=> !flags[uoe_pkg::BIT_LINE_CHANGE];
  endproperty
  a_w1c_line: assert property (p_w1c_line) else $error("line flag not cleared");

  // A clear landing with its event must not lose the event
  property p_set_wins;
    @(posedge CLK_SYS) disable iff (!rst_n)
      (events != 8'h00) |=> (flags & $past(events)) == $past(events);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

  property p_reset_zero;
    @(posedge CLK_SYS) disable iff (!rst_n)
      $rose(rst_n) |-> flags == uoe_pkg::FLAGS_RESET && enables == uoe_pkg::ENABLES_RESET
      && !OTG_IRQ;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("state not zero after reset");
endmodule : uoe_event_flags
`default_nettype wire

/* File: hw/placeholder_none.sv */
// Intentionally empty compile unit marker
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* File: testbench/uoe_connector_model.sv */
// Connector side: ID pin, raw undebounced line state and VBUS comparators
`timescale 1ns/10ps
`default_nettype none
module uoe_connector_model (
  input wire logic clk,
  output logic connector_id,
  output logic line_se0,
  output logic line_j,
  output logic b_sess_valid,
  output logic b_sess_end,
  output logic a_vbus_valid
);
  // Idle: no cable (B role), bus in J, VBUS low
  initial begin
    connector_id = 1'b1;
    line_se0 = 1'b0;
    line_j = 1'b1;
    {b_sess_valid, b_sess_end, a_vbus_valid} = 3'h0;
  end
  // Levels change just after an edge so no sample sees a half-step
  task automatic set_id(input logic v);
    @(posedge clk);
    connector_id <= v;
  endtask : set_id
  // K is shown as both indications low
  task automatic set_line(input logic se0, input logic j);
    @(posedge clk);
    line_se0 <= se0;
    line_j <= j;
  endtask : set_line
  task automatic set_vbus(input logic [2:0] v);
    @(posedge clk);
    {b_sess_valid, b_sess_end, a_vbus_valid} <= v;
  endtask : set_vbus
endmodule : uoe_connector_model
`default_nettype wire

/* File: testbench/uoe_event_flags_bench.sv */
// Self-checking bench for the OTG event-flag block
`timescale 1ns/10ps
`default_nettype none
module uoe_event_flags_bench;
  localparam logic [7:0] CFG = 8'hA7;
  localparam logic [7:0] BLOCK_REVISION_NUMBER = 8'h12;
  localparam logic [7:0] XTRA = 8'h66;
  localparam logic [7:0] FLG = uoe_pkg::OFF_EVENT_FLAGS;
  localparam logic [7:0] ENA = uoe_pkg::OFF_EVENT_ENABLES;
  logic clk, rst_n, cyc, stb, we, ack, irq;
  logic id, se0, j, bsv, bse, avv;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_i, dat_o, rd;
  logic [1:0] ls [3];
  int n_fail, samples_checked;
  uoe_event_flags #(.CONFIG_NUMBER(CFG), .REVISION(BLOCK_REVISION_NUMBER), .EXTRA_INFO(XTRA), .MS_CYCLES(20)) dut (
    .CLK_SYS(clk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
    .CONNECTOR_ID(id), .LINE_SE0(se0), .LINE_J(j), .B_SESSION_VALID(bsv),
    .B_SESSION_END(bse), .A_VBUS_VALID(avv), .OTG_IRQ(irq));
  uoe_connector_model cm (.clk(clk), .connector_id(id), .line_se0(se0), .line_j(j),
    .b_sess_valid(bsv), .b_sess_end(bse), .a_vbus_valid(avv));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Ack is read before this edge's updates land, so the sample is race-free
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, dat_i, sel} <= {2'h3, w, a, d, 4'hF};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk({31'h0, ack}, 32'h1, "bus ack");
    rd = dat_o;
    {cyc, stb, we} <= 3'h0;
  endtask : wb
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic flag_is(input int b, input logic v, input string m);
    wb(1'b0, FLG, 32'h0);
    chk({31'h0, rd[b]}, {31'h0, v}, m);
  endtask : flag_is
  task automatic t_ident();
    wb(1'b0, FLG, 32'h0);
    chk(rd, 32'h0, "flags reset");
    wb(1'b0, ENA, 32'h0);
    chk(rd, 32'h0, "enables reset");
    chk({31'h0, irq}, 32'h0, "irq reset");
    wb(1'b1, uoe_pkg::OFF_ID_COMPLEMENT, 32'hFFFF_FFFF);
    wb(1'b0, uoe_pkg::OFF_ID_COMPLEMENT, 32'h0);
    chk(rd, {24'h0, ~CFG}, "id complement");
    wb(1'b0, uoe_pkg::OFF_BLOCK_REVISION, 32'h0);
    chk(rd, {24'h0, BLOCK_REVISION_NUMBER}, "revision");
    wb(1'b0, uoe_pkg::OFF_EXTRA_INFO, 32'h0);
    chk(rd, {24'h0, XTRA}, "extra info");
    wb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0, "unmapped");
    $display("test ident done");
  endtask : t_ident
  task automatic t_enables();
    wb(1'b1, ENA, 32'hFFFF_FFFF);
    wb(1'b0, ENA, 32'h0);
    chk(rd, 32'h0000_00ED, "enables mask");
    wb(1'b1, FLG, 32'hFFFF_FFFF);
    wb(1'b1, ENA, 32'h0);
    wb(1'b0, ENA, 32'h0);
    chk(rd, 32'h0, "enables clear");
    $display("test enables done");
  endtask : t_enables
  task automatic t_id();
    cm.set_id(1'b0);
    idle(8);
    flag_is(7, 1'b1, "id change set");
    wb(1'b1, FLG, 32'h80);
    flag_is(7, 1'b0, "id change clear");
    wb(1'b1, FLG, 32'h40);
    idle(25);
    flag_is(6, 1'b1, "ms tick");
    $display("test id tick done");
  endtask : t_id
  // J to K, K to SE0, SE0 to J
  task automatic t_line();
    ls = '{2'b00, 2'b10, 2'b01};
    foreach (ls[k]) begin
      cm.set_line(ls[k][1], ls[k][0]);
      wb(1'b1, FLG, 32'h20);
      flag_is(5, 1'b0, "line not yet stable");
      idle(30);
      flag_is(5, 1'b1, "line change");
    end
    $display("test line done");
  endtask : t_line
  task automatic vb(input logic [2:0] v, input int b, input logic e);
    cm.set_vbus(v);
    idle(8);
    flag_is(b, e, "vbus flag");
  endtask : vb
  task automatic t_vbus();
    wb(1'b1, FLG, 32'hFF);
    vb(3'b001, 0, 1'b1);
    vb(3'b011, 2, 1'b0);
    cm.set_id(1'b1);
    idle(8);
    wb(1'b1, FLG, 32'hFF);
    vb(3'b111, 3, 1'b1);
    vb(3'b101, 2, 1'b1);
    vb(3'b100, 0, 1'b0);
    $display("test vbus done");
  endtask : t_vbus
  task automatic t_irq();
    wb(1'b1, ENA, 32'h08);
    idle(3);
    chk({31'h0, irq}, 32'h1, "irq on");
    wb(1'b1, FLG, 32'h08);
    idle(3);
    chk({31'h0, irq}, 32'h0, "irq off");
    wb(1'b1, ENA, 32'h40);
    idle(25);
    chk({31'h0, irq}, 32'h1, "irq tick");
    $display("test irq done");
  endtask : t_irq
  // Mid-run reset with live flags and enables must clear them all
  task automatic t_reset();
    wb(1'b1, ENA, 32'hED);
    cm.set_id(1'b0);
    idle(8);
    chk({31'h0, irq}, 32'h1, "irq before reset");
    rst_n <= 1'b0;
    idle(2);
    chk({31'h0, irq}, 32'h0, "irq in reset");
    rst_n <= 1'b1;
    idle(3);
    wb(1'b0, FLG, 32'h0);
    chk(rd, 32'h0, "flags after reset");
    wb(1'b0, ENA, 32'h0);
    chk(rd, 32'h0, "enables after reset");
    chk({31'h0, irq}, 32'h0, "irq after reset");
    $display("test reset done");
  endtask : t_reset
  initial begin
    {rst_n, cyc, stb, we, adr, sel, dat_i} = '0;
    n_fail = 0;
    samples_checked = 0;
    idle(2);
    rst_n <= 1'b1;
    idle(3);
    t_ident();
    t_enables();
    t_id();
    t_line();
    t_vbus();
    t_irq();
    t_reset();
    final_report();
  end
  // Whole sequence takes well under ten thousand cycles
  initial begin
    #50000;
    n_fail++;
    final_report();
  end
endmodule : uoe_event_flags_bench
`default_nettype wire
